// >>> logic/aoi_pkg.sv
// Constants, register map and types for the acceleration output and init block
`default_nettype none

package aoi_pkg;
    localparam int CLK_NS        = 10;
    localparam int SAMPLE_NS     = 16000;
    localparam int INTERP_STEPS  = 16;
    localparam int STEP_CYC      = SAMPLE_NS / INTERP_STEPS / CLK_NS;
    localparam int PCM_HZ        = 4000000;
    localparam int PCM_DIV       = 1000000000 / CLK_NS / PCM_HZ;
    localparam int T_DSI_INIT_US = 100;
    localparam int T_DSP_INIT_US = 10000;
    localparam int SAMPLE_W      = 26;
    localparam int WORD_W        = 10;
    localparam int PCM_W         = 9;
    localparam int WORD_MSB      = 21;
    localparam int LSB_W10       = 12;
    localparam int LSB_W9        = 13;
    localparam int LSB_W8        = 14;
    localparam int REG_AW        = 3;
    localparam int REG_DW        = 16;
    localparam logic [2:0] ADDR_CONFIG   = 3'h0;
    localparam logic [2:0] ADDR_STATUS   = 3'h1;
    localparam logic [2:0] ADDR_IRQ_STAT = 3'h2;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
    localparam logic [2:0] ADDR_WORD     = 3'h4;
    localparam int CFG_PCM_EN    = 0;
    localparam int CFG_FSEL_LSB  = 1;
    localparam int CFG_WSEL_LSB  = 3;
    localparam logic [4:0] CONFIG_RST = 5'h00;
    localparam int IRQ_READY     = 0;
    localparam int IRQ_VALID     = 1;
    localparam int IRQ_DROPPED   = 2;
    localparam int IRQ_SAT       = 3;
    localparam logic [9:0] INVALID_WORD = 10'h3ff;
    localparam logic [9:0] SAT_POS_10 = 10'h1ff;
    localparam logic [9:0] SAT_NEG_10 = 10'h200;
    localparam logic [9:0] SAT_POS_9  = 10'h0ff;
    localparam logic [9:0] SAT_NEG_9  = 10'h300;
    localparam logic [9:0] SAT_POS_8  = 10'h07f;
    localparam logic [9:0] SAT_NEG_8  = 10'h380;

    typedef enum logic [1:0] {
        ST_FUSE = 2'b00,
        ST_DSI  = 2'b01,
        ST_RUN  = 2'b11
    } aoi_stage_t;

    typedef enum logic [1:0] {
        WSEL_10 = 2'b00,
        WSEL_9  = 2'b01,
        WSEL_8  = 2'b10
    } aoi_wsel_t;
endpackage

`default_nettype wire

// >>> logic/aoi_pcm_if.sv
// Link between the block core and its test pulse modulator
`default_nettype none

interface aoi_pcm_if;
    logic                      enable;
    logic [aoi_pkg::PCM_W-1:0] level;
    logic                      pcm_q;
    modport src (output enable, output level, input pcm_q);
    modport mod (input enable, input level, output pcm_q);
endinterface

`default_nettype wire

// >>> logic/aoi_pcm_mod.sv
// First-order pulse density modulator for the test output
`default_nettype none

module aoi_pcm_mod #(
    parameter int DIV = aoi_pkg::PCM_DIV
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Core side
    aoi_pcm_if.mod    pcm
);
    localparam int W = aoi_pkg::PCM_W;

    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic         out_r;
    logic         out_nxt;
    logic         tick;
    logic [W:0]   sum;

    always_comb begin
        tick    = (div_r == 8'(DIV - 1));
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        sum     = {1'b0, acc_r} + {1'b0, pcm.level};
        acc_nxt = acc_r;
        out_nxt = out_r;
        if (!pcm.enable) begin
            acc_nxt = '0;
            out_nxt = 1'b0;
        end else if (tick) begin
            acc_nxt = sum[W-1:0];
            out_nxt = sum[W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            div_r <= 8'h00;
            acc_r <= '0;
            out_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            acc_r <= acc_nxt;
            out_r <= out_nxt;
        end
    end

    assign pcm.pcm_q = out_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_pcm_idle_low: assert property (
        !pcm.enable |=> !out_r) else $error("test pulse output active while disabled");
    a_pcm_tick_rate: assert property (
        !$past(tick) && $past(pcm.enable) |-> $stable(out_r))
        else $error("test pulse output changed off the 4 MHz tick");
endmodule

`default_nettype wire

// >>> logic/aoi_core.sv
// Interpolation, output scaling, start-up sequencing and registers
//
// Added by the designer: the plain strobed port and the placing of the registers.
`default_nettype none

module aoi_core #(
    parameter int T_DSI_US = aoi_pkg::T_DSI_INIT_US,
    parameter int T_DSP_US = aoi_pkg::T_DSP_INIT_US,
    parameter int DSI_CYC  = T_DSI_US * 1000 / aoi_pkg::CLK_NS,
    parameter int DSP_CYC  = T_DSP_US * 1000 / aoi_pkg::CLK_NS
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    // Register port
    input  wire logic [aoi_pkg::REG_AW-1:0]    reg_addr,
    input  wire logic [aoi_pkg::REG_DW-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [aoi_pkg::REG_DW-1:0]    reg_rdata,
    // Filter side
    input  wire logic [aoi_pkg::SAMPLE_W-1:0]  sample_in,
    input  wire logic                          sample_valid,
    output logic      [1:0]                    filter_select,
    // Command decoder side
    input  wire logic                          clear_cmd,
    input  wire logic                          selftest_cmd,
    input  wire logic                          accel_req,
    input  wire logic                          accel_long,
    output logic                               resp_valid,
    output logic      [aoi_pkg::WORD_W-1:0]    resp_data,
    output logic                               resp_invalid,
    output logic                               status_flag,
    output logic                               selftest_active_flag,
    output logic                               bus_ready,
    // Interrupt and test pin
    output logic                               irq,
    output logic                               pcm_out
);
    localparam int SW = aoi_pkg::SAMPLE_W;
    localparam int WW = aoi_pkg::WORD_W;
    localparam logic [31:0] DSI_LAST = 32'(DSI_CYC - 1);
    localparam logic [31:0] DSP_LAST = 32'(DSP_CYC - 1);
    localparam logic [7:0]  STEP_LAST = 8'(aoi_pkg::STEP_CYC - 1);

    aoi_pkg::aoi_stage_t stage_r;
    aoi_pkg::aoi_stage_t stage_nxt;
    logic [31:0]   cnt_r;
    logic [31:0]   cnt_nxt;
    logic [7:0]    step_r;
    logic [7:0]    step_nxt;
    logic [3:0]    phase_r;
    logic [3:0]    phase_nxt;
    logic [SW-1:0] prev_r;
    logic [SW-1:0] prev_nxt;
    logic [SW-1:0] cur_r;
    logic [SW-1:0] cur_nxt;
    logic [4:0]    config_r;
    logic [4:0]    config_nxt;
    logic [3:0]    irq_stat_r;
    logic [3:0]    irq_stat_nxt;
    logic [3:0]    irq_mask_r;
    logic [3:0]    irq_mask_nxt;
    logic [WW-1:0] last_word_r;
    logic [WW-1:0] last_word_nxt;
    logic [aoi_pkg::REG_DW-1:0] rdata_r;
    logic [aoi_pkg::REG_DW-1:0] rdata_nxt;
    logic          resp_valid_r;
    logic          resp_valid_nxt;
    logic [WW-1:0] resp_data_r;
    logic [WW-1:0] resp_data_nxt;
    logic          resp_inv_r;
    logic          resp_inv_nxt;
    logic          status_r;
    logic          status_nxt;
    logic          selftest_r;
    logic          selftest_nxt;
    logic          ready_r;
    logic          ready_nxt;
    logic          irq_r;
    logic          irq_nxt;

    logic signed [SW:0]   diff;
    logic signed [SW+6:0] prod;
    logic signed [SW:0]   interp;
    logic                 over;
    logic [WW-1:0]        word;
    logic [3:0]           events;

    aoi_pcm_if pcm_bus ();

    aoi_pcm_mod u_pcm (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pcm     (pcm_bus.mod)
    );

    // Interpolated value and scaled word
    always_comb begin
        diff   = $signed({cur_r[SW-1], cur_r}) - $signed({prev_r[SW-1], prev_r});
        prod   = diff * $signed({2'b00, phase_r});
        interp = $signed({prev_r[SW-1], prev_r}) + (SW+1)'(prod >>> 4);
        over   = !((&interp[SW:aoi_pkg::WORD_MSB]) || !(|interp[SW:aoi_pkg::WORD_MSB]));
        unique case (aoi_pkg::aoi_wsel_t'(config_r[aoi_pkg::CFG_WSEL_LSB +: 2]))
            aoi_pkg::WSEL_10: begin
                word = interp[aoi_pkg::WORD_MSB:aoi_pkg::LSB_W10];
                if (over) begin
                    word = interp[SW] ? aoi_pkg::SAT_NEG_10 : aoi_pkg::SAT_POS_10;
                end
            end
            aoi_pkg::WSEL_9: begin
                word = {interp[aoi_pkg::WORD_MSB], interp[aoi_pkg::WORD_MSB:aoi_pkg::LSB_W9]};
                if (over) begin
                    word = interp[SW] ? aoi_pkg::SAT_NEG_9 : aoi_pkg::SAT_POS_9;
                end
            end
            default: begin
                word = {{2{interp[aoi_pkg::WORD_MSB]}},
                        interp[aoi_pkg::WORD_MSB:aoi_pkg::LSB_W8]};
                if (over) begin
                    word = interp[SW] ? aoi_pkg::SAT_NEG_8 : aoi_pkg::SAT_POS_8;
                end
            end
        endcase
    end

    // Next state of sequencer, sample store, responses and registers
    always_comb begin
        stage_nxt     = stage_r;
        cnt_nxt       = cnt_r;
        step_nxt      = step_r;
        phase_nxt     = phase_r;
        prev_nxt      = prev_r;
        cur_nxt       = cur_r;
        config_nxt    = config_r;
        irq_mask_nxt  = irq_mask_r;
        last_word_nxt = last_word_r;
        rdata_nxt     = '0;
        resp_valid_nxt = 1'b0;
        resp_data_nxt = '0;
        resp_inv_nxt  = 1'b0;
        events        = 4'h0;

        if (clear_cmd) begin
            stage_nxt = aoi_pkg::ST_FUSE;
            cnt_nxt   = '0;
        end else begin
            unique case (stage_r)
                aoi_pkg::ST_FUSE: begin
                    cnt_nxt = cnt_r + 32'h1;
                    if (cnt_r == DSI_LAST) begin
                        stage_nxt = aoi_pkg::ST_DSI;
                        cnt_nxt   = '0;
                        events[aoi_pkg::IRQ_READY] = 1'b1;
                    end
                end
                aoi_pkg::ST_DSI: begin
                    cnt_nxt = cnt_r + 32'h1;
                    if (cnt_r == DSP_LAST) begin
                        stage_nxt = aoi_pkg::ST_RUN;
                        cnt_nxt   = '0;
                        events[aoi_pkg::IRQ_VALID] = 1'b1;
                    end
                end
                aoi_pkg::ST_RUN: begin
                    cnt_nxt = '0;
                end
                default: begin
                    stage_nxt = aoi_pkg::ST_FUSE;
                    cnt_nxt   = '0;
                end
            endcase
        end

        status_nxt   = (stage_nxt != aoi_pkg::ST_RUN);
        selftest_nxt = (stage_nxt == aoi_pkg::ST_RUN) && selftest_cmd;
        ready_nxt    = (stage_nxt != aoi_pkg::ST_FUSE);

        if (sample_valid) begin
            prev_nxt  = cur_r;
            cur_nxt   = sample_in;
            step_nxt  = 8'h00;
            phase_nxt = 4'h0;
        end else if (step_r == STEP_LAST) begin
            step_nxt  = 8'h00;
            phase_nxt = (phase_r == 4'hf) ? 4'hf : phase_r + 4'h1;
        end else begin
            step_nxt  = step_r + 8'h01;
        end

        if (accel_req) begin
            unique case (stage_r)
                aoi_pkg::ST_RUN: begin
                    resp_valid_nxt = 1'b1;
                    resp_data_nxt  = word;
                    last_word_nxt  = word;
                    events[aoi_pkg::IRQ_SAT] = over;
                end
                aoi_pkg::ST_DSI: begin
                    resp_valid_nxt = 1'b1;
                    resp_data_nxt  = accel_long ? aoi_pkg::INVALID_WORD : '0;
                    resp_inv_nxt   = accel_long;
                end
                default: begin
                    events[aoi_pkg::IRQ_DROPPED] = 1'b1;
                end
            endcase
        end

        if (reg_wr && reg_addr == aoi_pkg::ADDR_CONFIG) begin
            config_nxt = reg_wdata[4:0];
        end
        if (reg_wr && reg_addr == aoi_pkg::ADDR_IRQ_MASK) begin
            irq_mask_nxt = reg_wdata[3:0];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                aoi_pkg::ADDR_CONFIG:   rdata_nxt = {11'h000, config_r};
                aoi_pkg::ADDR_STATUS:   rdata_nxt = {12'h000, stage_r, selftest_r, status_r};
                aoi_pkg::ADDR_IRQ_STAT: rdata_nxt = {12'h000, irq_stat_r};
                aoi_pkg::ADDR_IRQ_MASK: rdata_nxt = {12'h000, irq_mask_r};
                aoi_pkg::ADDR_WORD:     rdata_nxt = {6'h00, last_word_r};
                default:                rdata_nxt = '0;
            endcase
        end
        irq_stat_nxt = ((reg_rd && reg_addr == aoi_pkg::ADDR_IRQ_STAT) ? 4'h0 : irq_stat_r)
                     | events;
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stage_r      <= aoi_pkg::ST_FUSE;
            cnt_r        <= '0;
            step_r       <= 8'h00;
            phase_r      <= 4'h0;
            prev_r       <= '0;
            cur_r        <= '0;
            config_r     <= aoi_pkg::CONFIG_RST;
            irq_stat_r   <= 4'h0;
            irq_mask_r   <= 4'h0;
            last_word_r  <= '0;
            rdata_r      <= '0;
            resp_valid_r <= 1'b0;
            resp_data_r  <= '0;
            resp_inv_r   <= 1'b0;
            status_r     <= 1'b1;
            selftest_r   <= 1'b0;
            ready_r      <= 1'b0;
            irq_r        <= 1'b0;
        end else begin
            stage_r      <= stage_nxt;
            cnt_r        <= cnt_nxt;
            step_r       <= step_nxt;
            phase_r      <= phase_nxt;
            prev_r       <= prev_nxt;
            cur_r        <= cur_nxt;
            config_r     <= config_nxt;
            irq_stat_r   <= irq_stat_nxt;
            irq_mask_r   <= irq_mask_nxt;
            last_word_r  <= last_word_nxt;
            rdata_r      <= rdata_nxt;
            resp_valid_r <= resp_valid_nxt;
            resp_data_r  <= resp_data_nxt;
            resp_inv_r   <= resp_inv_nxt;
            status_r     <= status_nxt;
            selftest_r   <= selftest_nxt;
            ready_r      <= ready_nxt;
            irq_r        <= irq_nxt;
        end
    end

    assign pcm_bus.enable        = config_r[aoi_pkg::CFG_PCM_EN];
    assign pcm_bus.level         = {~interp[aoi_pkg::WORD_MSB],
                                    interp[aoi_pkg::WORD_MSB-1:aoi_pkg::LSB_W9]};
    assign pcm_out               = pcm_bus.pcm_q;
    assign filter_select         = config_r[aoi_pkg::CFG_FSEL_LSB +: 2];
    assign reg_rdata             = rdata_r;
    assign resp_valid            = resp_valid_r;
    assign resp_data             = resp_data_r;
    assign resp_invalid          = resp_inv_r;
    assign status_flag           = status_r;
    assign selftest_active_flag  = selftest_r;
    assign bus_ready             = ready_r;
    assign irq                   = irq_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_req_fuse;
        accel_req && stage_r == aoi_pkg::ST_FUSE && !clear_cmd;
    endsequence
    sequence s_req_ready(bit lng);
        accel_req && stage_r == aoi_pkg::ST_DSI && accel_long == lng;
    endsequence

    a_fuse_no_answer: assert property (
        s_req_fuse |=> !resp_valid_r) else $error("answer given during fuse copy");
    a_fuse_flag_values: assert property (
        stage_r == aoi_pkg::ST_FUSE |-> status_r && !selftest_r)
        else $error("flags wrong during fuse copy");
    a_ready_short_zero: assert property (
        s_req_ready(1'b0) |=> resp_valid_r && resp_data_r == '0 && status_r)
        else $error("short read before valid data not zero");
    a_ready_long_invalid: assert property (
        s_req_ready(1'b1) |=> resp_valid_r && resp_inv_r && resp_data_r == aoi_pkg::INVALID_WORD)
        else $error("long read before valid data not marked invalid");
    a_run_flag_clear: assert property (
        $rose(stage_r == aoi_pkg::ST_RUN) |-> !status_r && $past(cnt_r) == DSP_LAST)
        else $error("status flag not cleared at end of signal chain init");
    a_clear_restarts: assert property (
        clear_cmd |=> stage_r == aoi_pkg::ST_FUSE && status_r && !selftest_r
                      ##1 !resp_valid_r) else $error("clear command did not restart init");
    a_phase_restart: assert property (
        sample_valid |=> phase_r == 4'h0 ##(aoi_pkg::STEP_CYC) phase_r == 4'h1 || sample_valid
                         || $past(sample_valid)) else $error("interpolation step timing wrong");
    a_word_trunc_10: assert property (
        accel_req && stage_r == aoi_pkg::ST_RUN && !over
        && config_r[aoi_pkg::CFG_WSEL_LSB +: 2] == 2'b00
        |=> resp_data_r == $past(interp[aoi_pkg::WORD_MSB:aoi_pkg::LSB_W10]))
        else $error("10-bit word not taken from bits 21 to 12");
    a_word_saturate: assert property (
        accel_req && stage_r == aoi_pkg::ST_RUN && over && !interp[SW]
        && config_r[aoi_pkg::CFG_WSEL_LSB +: 2] == 2'b00
        |=> resp_data_r == aoi_pkg::SAT_POS_10) else $error("positive overrange not saturated");
    a_filter_sel_write: assert property (
        reg_wr && reg_addr == aoi_pkg::ADDR_CONFIG
        |=> filter_select == $past(reg_wdata[aoi_pkg::CFG_FSEL_LSB +: 2]))
        else $error("filter select not updated by config write");
endmodule

`default_nettype wire

// >>> tb/aoi_filter_model.sv
// Filter stand-in: delivers a held value once per sample period
`default_nettype none

module aoi_filter_model #(
    parameter int PERIOD = aoi_pkg::SAMPLE_NS / aoi_pkg::CLK_NS
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    // Value to deliver
    input  wire logic [aoi_pkg::SAMPLE_W-1:0]  value,
    // Filter output
    output logic      [aoi_pkg::SAMPLE_W-1:0]  sample_in,
    output logic                               sample_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_r <= 0;
            sample_valid <= 1'b0;
            sample_in <= '0;
        end else begin
            sample_valid <= (cnt_r == PERIOD - 1);
            // Bus toggles outside the strobe so stale data never looks held
            sample_in <= (cnt_r == PERIOD - 1) ? value : ~sample_in;
            cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
        end
    end
endmodule

`default_nettype wire

// >>> tb/tb_aoi_core.sv
// Self-checking bench for the acceleration output and init block
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_aoi_core;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [25:0] XV = 26'h0100000;
    logic        clk_sys, reset_n, reg_wr, reg_rd, clear_cmd, selftest_cmd;
    logic        accel_req, accel_long, resp_valid, resp_invalid, sample_valid;
    logic        status_flag, selftest_active_flag, bus_ready, irq, pcm_out;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [25:0] sample_in, value;
    logic [1:0]  filter_select;
    logic [9:0]  resp_data;
    logic [25:0] vals [4] = '{26'h0123456, 26'h3edcbaa, 26'h0400000, 26'h3800000};
    int          failures = 0, checks = 0, cyc = 0, t0, c, e;

    aoi_core #(.DSI_CYC(40), .DSP_CYC(200)) i_dut (.clk_sys, .reset_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_in, .sample_valid,
        .filter_select, .clear_cmd, .selftest_cmd, .accel_req, .accel_long, .resp_valid,
        .resp_data, .resp_invalid, .status_flag, .selftest_active_flag, .bus_ready,
        .irq, .pcm_out);
    aoi_filter_model i_src (.clk_sys, .reset_n, .value, .sample_in, .sample_valid);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            give_verdict();
        end
    end

    function automatic logic [9:0] exp_word(input logic [25:0] v, input int w);
        logic signed [21:0] s;
        logic [9:0]         pos;
        int                 lsb;
        lsb = (w > 2) ? 14 : 12 + w;
        s = v[21:0];
        pos = 10'((1 << (21 - lsb)) - 1);
        if (v[25:21] != {5{v[21]}}) return v[25] ? ~pos : pos;
        return 10'(s >>> lsb);
    endfunction

    task give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [2:0] a, input logic [15:0] x);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        `CHK("reg_rdata", x, reg_rdata)
    endtask

    task ask(input logic lng, input logic ev, input logic [9:0] ed, input logic ei);
        @(posedge clk_sys);
        accel_req <= 1'b1;
        accel_long <= lng;
        @(posedge clk_sys);
        accel_req <= 1'b0;
        @(negedge clk_sys);
        `CHK("resp_valid", ev, resp_valid)
        `CHK("resp_data", ed, resp_data)
        `CHK("resp_invalid", ei, resp_invalid)
    endtask

    task wait_for(input int which, input int lim);
        int n;
        n = 0;
        while (n < lim && (which == 0 ? bus_ready !== 1'b1 : status_flag !== 1'b0)) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    task wait_sample;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sample_valid !== 1'b1 && n < 2000);
    endtask

    task load(input logic [25:0] v, input int n);
        wait_sample();
        value <= v;
        repeat (n) wait_sample();
    endtask

    task pcm_cnt(input int n);
        c = 0;
        repeat (n) begin
            @(negedge clk_sys);
            c += (pcm_out !== 1'b0);
        end
    endtask

    initial begin
        {reg_wr, reg_rd, clear_cmd, accel_req, accel_long} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        value = '0;
        selftest_cmd = 1'b1;
        reset_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(aoi_pkg::ADDR_CONFIG, 16'h0000);
        rd(aoi_pkg::ADDR_IRQ_MASK, 16'h0000);
        wr(aoi_pkg::ADDR_IRQ_MASK, 16'h0004);
        ask(1'b0, 1'b0, 10'h000, 1'b0);
        rd(aoi_pkg::ADDR_STATUS, 16'h0001);
        `CHK("selftest_active_flag", 1'b0, selftest_active_flag)
        `CHK("irq", 1'b1, irq)
        rd(aoi_pkg::ADDR_IRQ_STAT, 16'h0004);
        rd(aoi_pkg::ADDR_IRQ_STAT, 16'h0000);
        `CHK("irq", 1'b0, irq)
        $display("END fuse");
        wait_for(0, 100);
        `CHK("bus_ready", 1'b1, bus_ready)
        ask(1'b0, 1'b1, 10'h000, 1'b0);
        ask(1'b1, 1'b1, aoi_pkg::INVALID_WORD, 1'b1);
        rd(aoi_pkg::ADDR_STATUS, 16'h0005);
        selftest_cmd <= 1'b0;
        wait_for(1, 400);
        `CHK("status_flag", 1'b0, status_flag)
        `CHK("selftest_active_flag", 1'b0, selftest_active_flag)
        rd(aoi_pkg::ADDR_STATUS, 16'h000c);
        `CHK("irq", 1'b0, irq)
        rd(aoi_pkg::ADDR_IRQ_STAT, 16'h0003);
        rd(3'h5, 16'h0000);
        wr(aoi_pkg::ADDR_STATUS, 16'hffff);
        rd(aoi_pkg::ADDR_STATUS, 16'h000c);
        for (int f = 0; f < 4; f++) begin
            wr(aoi_pkg::ADDR_CONFIG, 16'(f << 1));
            rd(aoi_pkg::ADDR_CONFIG, 16'(f << 1));
            `CHK("filter_select", 2'(f), filter_select)
        end
        $display("END init");
        foreach (vals[i]) begin
            load(vals[i], 2);
            for (int w = 0; w < 4; w++) begin
                wr(aoi_pkg::ADDR_CONFIG, 16'(w << 3));
                ask(1'(w), 1'b1, exp_word(vals[i], w), 1'b0);
            end
        end
        rd(aoi_pkg::ADDR_IRQ_STAT, 16'h0008);
        $display("END scaling");
        wr(aoi_pkg::ADDR_CONFIG, 16'h0000);
        load(26'h0, 2);
        load(XV, 1);
        t0 = cyc;
        for (int p = 0; p < 16; p++) begin
            while (cyc < t0 + 49 + 100 * p) @(posedge clk_sys);
            ask(1'(p), 1'b1, exp_word(26'(int'(XV) * p / 16), 0), 1'b0);
        end
        rd(aoi_pkg::ADDR_WORD, 16'(exp_word(26'(int'(XV) * 15 / 16), 0)));
        $display("END interp");
        load(XV, 1);
        wr(aoi_pkg::ADDR_CONFIG, 16'h0001);
        pcm_cnt(1600);
        e = 1600 * int'({~XV[21], XV[20:13]}) / 512;
        `CHK("pcm_density", 1'b1, c >= e - 50 && c <= e + 50)
        wr(aoi_pkg::ADDR_CONFIG, 16'h0000);
        repeat (2) @(posedge clk_sys);
        pcm_cnt(200);
        `CHK("pcm_idle", 0, c)
        $display("END pcm");
        @(posedge clk_sys);
        clear_cmd <= 1'b1;
        @(posedge clk_sys);
        clear_cmd <= 1'b0;
        @(negedge clk_sys);
        `CHK("status_flag", 1'b1, status_flag)
        `CHK("bus_ready", 1'b0, bus_ready)
        ask(1'b0, 1'b0, 10'h000, 1'b0);
        wait_for(0, 100);
        `CHK("bus_ready", 1'b1, bus_ready)
        wait_for(1, 400);
        `CHK("status_flag", 1'b0, status_flag)
        $display("END clear");
        give_verdict();
    end
endmodule

`default_nettype wire
